// file: hw/sso_top.v
// startup sequencer option logic with its AXI4-Lite register slave
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "sso_map.vh"

// What this block does
// - option bit turns done pin into powerdown status
// - pipe bit delays done input one sequencer tick
// - drive bit: open drain or active-high done
// - non-single mode captures on every request or command
// - six-bit field sets master configuration clock frequency
// - two-bit field picks sequencer clock source
// - done release phase code, seven means keep
// - stall in chosen phase until impedance matches
// - tristate release phase, follow done, or keep
// - write enable release phase, follow done, or keep
// - phases counted in binary, read back in three-bit gray code
// - storage writes blocked while write enable inactive
// - user outputs high impedance while tristate asserted
// - match is AND of all bank match inputs
module sso_top #(
	parameter NUM_BANKS = 4,
	parameter NUM_IO = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire configuration_clock,
	input wire user_startup_clock,
	input wire test_port_clock,
	input wire done_pin_in,
	output reg done_pin_out,
	output reg done_pin_oe,
	input wire [NUM_BANKS-1:0] bank_match_in,
	input wire capture_request,
	output reg capture_strobe,
	output reg [5:0] master_clock_freq_select,
	output reg global_tristate,
	output reg global_write_enable,
	input wire [NUM_IO-1:0] user_oe_in,
	output reg [NUM_IO-1:0] user_oe_out,
	input wire storage_we_in,
	output reg storage_we_out
);

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [2:0] to_gray;
	input [2:0] b;
	begin
		to_gray = b ^ {1'b0, b[2:1]};
	end
endfunction

// true once the phase has reached code+1 (codes 0..6 only)
function reached;
	input [2:0] phase;
	input [2:0] code;
	begin
		reached = ({1'b0, phase} >= ({1'b0, code} + 4'h1));
	end
endfunction

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
localparam SYW = 5 + NUM_BANKS;
reg [SYW-1:0] sy1_q;
reg [SYW-1:0] sy2_q;
wire [SYW-1:0] sy_in;
assign sy_in = {bank_match_in, capture_request, done_pin_in,
	test_port_clock, user_startup_clock, configuration_clock};

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		sy1_q <= {SYW{1'b0}};
		sy2_q <= {SYW{1'b0}};
	end
	else
	begin
		sy1_q <= sy_in;
		sy2_q <= sy1_q;
	end
end

wire cfg_clk_s = sy2_q[0];
wire usr_clk_s = sy2_q[1];
wire tst_clk_s = sy2_q[2];
wire done_s = sy2_q[3];
wire cap_s = sy2_q[4];
wire match_all = &sy2_q[SYW-1:5];

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [31:0] opt_q;
reg [31:0] opt_d;
reg [3:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg aw_have_q;
reg w_have_q;
reg cmd_start_q;
reg cmd_cap_q;
reg cmd_readback_capture_reset_cmd_q;
integer i;

wire aw_hs = s_axi_awvalid && s_axi_awready;
wire w_hs = s_axi_wvalid && s_axi_wready;
wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
wire wr_opt = do_write && (awaddr_q == `SSO_OFS_OPTIONS);
wire wr_cmd = do_write && (awaddr_q == `SSO_OFS_COMMAND);
wire wr_ok = wr_opt || wr_cmd;

always @*
begin
	opt_d = opt_q;
	for (i = 0; i < 4; i = i + 1)
	begin
		if (wstrb_q[i])
			opt_d[i*8 +: 8] = wdata_q[i*8 +: 8];
	end
	opt_d = opt_d & `SSO_OPT_MASK;
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `SSO_RESP_OKAY;
		awaddr_q <= 4'h0;
		wdata_q <= 32'h00000000;
		wstrb_q <= 4'h0;
		aw_have_q <= 1'b0;
		w_have_q <= 1'b0;
		opt_q <= `SSO_OPT_RESET;
		cmd_start_q <= 1'b0;
		cmd_cap_q <= 1'b0;
		cmd_readback_capture_reset_cmd_q <= 1'b0;
	end
	else
	begin
		if (aw_hs)
		begin
			awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
			aw_have_q <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (w_hs)
		begin
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
			w_have_q <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		cmd_start_q <= wr_cmd && wstrb_q[0] && wdata_q[`SSO_CMD_START];
		cmd_cap_q <= wr_cmd && wstrb_q[0] && wdata_q[`SSO_CMD_CAPTURE];
		cmd_readback_capture_reset_cmd_q <= wr_cmd && wstrb_q[0] && wdata_q[`SSO_CMD_READBACK_CAPTURE_RESET_CMD];
		if (wr_opt)
			opt_q <= opt_d;
		if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `SSO_RESP_OKAY : `SSO_RESP_SLVERR;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

// ----------------------------------------------------------------
// option fields
// ----------------------------------------------------------------
wire opt_pwrdn = opt_q[`SSO_BIT_PWRDN];
wire opt_pipe = opt_q[`SSO_BIT_PIPE];
wire opt_drive = opt_q[`SSO_BIT_DRIVE];
wire opt_single = opt_q[`SSO_BIT_SINGLE];
wire [1:0] opt_src = opt_q[`SSO_SRC_HI:`SSO_SRC_LO];
wire [2:0] code_done = opt_q[`SSO_DONEC_HI:`SSO_DONEC_LO];
wire [2:0] code_match = opt_q[`SSO_MATCHC_HI:`SSO_MATCHC_LO];
wire [2:0] code_gts = opt_q[`SSO_GTSC_HI:`SSO_GTSC_LO];
wire [2:0] code_gwe = opt_q[`SSO_GWEC_HI:`SSO_GWEC_LO];

// ----------------------------------------------------------------
// sequencer clock selection and tick
// ----------------------------------------------------------------
reg seq_clk_sel;
reg seq_clk_last_q;
always @*
begin
	if (opt_src == `SSO_SRC_CFG)
		seq_clk_sel = cfg_clk_s;
	else if (opt_src == `SSO_SRC_USER)
		seq_clk_sel = usr_clk_s;
	else
		seq_clk_sel = tst_clk_s;
end
wire tick = seq_clk_sel && !seq_clk_last_q;

// ----------------------------------------------------------------
// startup sequencer
// ----------------------------------------------------------------
reg [2:0] phase_q;
reg running_q;
reg done_pipe_q;
reg done_rel_q;
reg stall_q;

wire done_seen = opt_pipe ? done_pipe_q : done_s;
wire at_last = (phase_q == `SSO_LAST_PHASE);
wire match_stall = (code_match != `SSO_CODE_KEEP)
	&& (phase_q == code_match) && !match_all;
wire done_hold = (code_done != `SSO_CODE_KEEP)
	&& reached(phase_q, code_done) && !done_seen;
wire advance = running_q && tick && !at_last && !match_stall && !done_hold;

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		seq_clk_last_q <= 1'b0;
		phase_q <= 3'h0;
		running_q <= 1'b0;
		done_pipe_q <= 1'b0;
		stall_q <= 1'b0;
	end
	else
	begin
		seq_clk_last_q <= seq_clk_sel;
		if (tick)
			done_pipe_q <= done_s;
		stall_q <= running_q && match_stall;
		if (cmd_start_q)
		begin
			phase_q <= 3'h0;
			running_q <= 1'b1;
		end
		else if (advance)
			phase_q <= phase_q + 3'h1;
	end
end

// ----------------------------------------------------------------
// global signals and done pin
// ----------------------------------------------------------------
reg gts_d;
reg gwe_d;
always @*
begin
	gts_d = 1'b1;
	gwe_d = 1'b0;
	if (running_q)
	begin
		if (code_gts == `SSO_CODE_DONE)
			gts_d = !done_seen;
		else if (code_gts != `SSO_CODE_KEEP)
			gts_d = !reached(phase_q, code_gts);
		if (code_gwe == `SSO_CODE_DONE)
			gwe_d = done_seen;
		else if (code_gwe != `SSO_CODE_KEEP)
			gwe_d = reached(phase_q, code_gwe);
	end
end

wire rel_d = running_q && (code_done != `SSO_CODE_KEEP)
	&& reached(phase_q, code_done);

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		global_tristate <= 1'b1;
		global_write_enable <= 1'b0;
		done_rel_q <= 1'b0;
		done_pin_out <= 1'b0;
		done_pin_oe <= 1'b1;
		user_oe_out <= {NUM_IO{1'b0}};
		storage_we_out <= 1'b0;
		master_clock_freq_select <= 6'h00;
	end
	else
	begin
		global_tristate <= gts_d;
		global_write_enable <= gwe_d;
		done_rel_q <= rel_d;
		user_oe_out <= gts_d ? {NUM_IO{1'b0}} : user_oe_in;
		storage_we_out <= gwe_d && storage_we_in;
		master_clock_freq_select <= opt_q[`SSO_FSEL_HI:`SSO_FSEL_LO];
		if (opt_pwrdn)
		begin
			// powerdown indicator: high once the sequence has finished
			done_pin_out <= running_q && at_last;
			done_pin_oe <= 1'b1;
		end
		else if (!rel_d)
		begin
			done_pin_out <= 1'b0;
			done_pin_oe <= 1'b1;
		end
		else
		begin
			done_pin_out <= opt_drive;
			done_pin_oe <= opt_drive;
		end
	end
end

// ----------------------------------------------------------------
// readback capture
// ----------------------------------------------------------------
reg cap_last_q;
reg armed_q;
wire cap_req = (cap_s && !cap_last_q) || cmd_cap_q;
wire cap_fire = cap_req && (!opt_single || armed_q);

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		cap_last_q <= 1'b0;
		armed_q <= 1'b1;
		capture_strobe <= 1'b0;
	end
	else
	begin
		cap_last_q <= cap_s;
		capture_strobe <= cap_fire;
		if (cmd_readback_capture_reset_cmd_q)
			armed_q <= 1'b1;
		else if (cap_fire && opt_single)
			armed_q <= 1'b0;
	end
end

// ----------------------------------------------------------------
// read channel
// ----------------------------------------------------------------
wire [31:0] status_w = {20'h00000, stall_q, running_q, armed_q, match_all,
	global_write_enable, global_tristate, done_s, done_rel_q,
	running_q && at_last, to_gray(phase_q)};

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `SSO_RESP_OKAY;
	end
	else if (s_axi_arvalid && s_axi_arready)
	begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= `SSO_RESP_OKAY;
		case ({s_axi_araddr[3:2], 2'b00})
			`SSO_OFS_OPTIONS: s_axi_rdata <= opt_q;
			`SSO_OFS_COMMAND: s_axi_rdata <= 32'h00000000;
			`SSO_OFS_STATUS: s_axi_rdata <= status_w;
			default:
			begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `SSO_RESP_SLVERR;
			end
		endcase
	end
	else if (s_axi_rvalid && s_axi_rready)
	begin
		s_axi_rvalid <= 1'b0;
		s_axi_arready <= 1'b1;
	end
end

endmodule // sso_top

// file: common/sso_map.vh
// register map, field positions and reset values of the startup option block
`ifndef SSO_MAP_VH
`define SSO_MAP_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SSO_OFS_OPTIONS 4'h0
`define SSO_OFS_COMMAND 4'h4
`define SSO_OFS_STATUS 4'h8
// ----------------------------------------------------------------
// options register fields
// ----------------------------------------------------------------
`define SSO_BIT_PWRDN 27
`define SSO_BIT_PIPE 25
`define SSO_BIT_DRIVE 24
`define SSO_BIT_SINGLE 23
`define SSO_FSEL_HI 22
`define SSO_FSEL_LO 17
`define SSO_SRC_HI 16
`define SSO_SRC_LO 15
`define SSO_DONEC_HI 14
`define SSO_DONEC_LO 12
`define SSO_MATCHC_HI 11
`define SSO_MATCHC_LO 9
`define SSO_GTSC_HI 5
`define SSO_GTSC_LO 3
`define SSO_GWEC_HI 2
`define SSO_GWEC_LO 0
`define SSO_OPT_RESET 32'h00003E2C
`define SSO_OPT_MASK 32'h0BFFFE3F
// ----------------------------------------------------------------
// phase codes and clock sources
// ----------------------------------------------------------------
`define SSO_CODE_KEEP 3'h7
`define SSO_CODE_DONE 3'h6
`define SSO_SRC_CFG 2'h0
`define SSO_SRC_USER 2'h1
`define SSO_LAST_PHASE 3'h7
// ----------------------------------------------------------------
// command register bits
// ----------------------------------------------------------------
`define SSO_CMD_START 0
`define SSO_CMD_CAPTURE 1
`define SSO_CMD_READBACK_CAPTURE_RESET_CMD 2
// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define SSO_RESP_OKAY 2'h0
`define SSO_RESP_SLVERR 2'h2
`endif

// file: testbench/sso_checker.sv
// port assertions of the startup option block
`timescale 1ns/1ps
module sso_checker #(
	parameter NUM_IO = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire capture_strobe,
	input wire global_tristate,
	input wire global_write_enable,
	input wire done_pin_oe,
	input wire [NUM_IO-1:0] user_oe_out,
	input wire storage_we_in,
	input wire storage_we_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----
	// bus timing
	// ----
	sequence wr_taken_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_answer_s;
		!s_axi_awready ##1 s_axi_bvalid;
	endsequence
	wr_answer_a: assert property (wr_taken_s |=> wr_answer_s)
		else $error("write answer late");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	// ----
	// startup outputs
	// ----
	reset_out_a: assert property ($rose(aresetn) |-> global_tristate && !global_write_enable && done_pin_oe)
		else $error("bad state after reset");
	hiz_hold_a: assert property (global_tristate && $past(global_tristate) |-> user_oe_out == '0)
		else $error("output enabled in tristate");
	we_block_a: assert property (!global_write_enable && !$past(global_write_enable) |-> !storage_we_out)
		else $error("write passed while blocked");
	we_pass_a: assert property (global_write_enable && $past(global_write_enable && storage_we_in) |-> storage_we_out)
		else $error("write lost while enabled");
	cap_pulse_a: assert property (capture_strobe |=> !capture_strobe)
		else $error("capture strobe too long");
endmodule // sso_checker
bind sso_top sso_checker #(.NUM_IO(NUM_IO)) u_chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.capture_strobe(capture_strobe),
	.global_tristate(global_tristate),
	.global_write_enable(global_write_enable),
	.done_pin_oe(done_pin_oe),
	.user_oe_out(user_oe_out),
	.storage_we_in(storage_we_in),
	.storage_we_out(storage_we_out)
);

// file: testbench/sso_pin_model.sv
// pin side model: sequencer clock sources and pulled-up done pin
`timescale 1ns/1ps
module sso_pin_model (
	input wire [1:0] clk_sel,
	input wire run,
	input wire done_pin_out,
	input wire done_pin_oe,
	output wire configuration_clock,
	output wire user_startup_clock,
	output wire test_port_clock,
	output wire done_pin_in
);
	logic tick = 1'h0;
	// slow clock, held low outside a run
	always #70 tick = run ? ~tick : 1'h0;
	assign configuration_clock = (clk_sel == 2'h0) & tick;
	assign user_startup_clock = (clk_sel == 2'h1) & tick;
	assign test_port_clock = clk_sel[1] & tick;
	// released pin is pulled high
	assign done_pin_in = done_pin_oe ? done_pin_out : 1'h1;
endmodule // sso_pin_model

// file: testbench/sso_top_tb_top.sv
// self-checking bench of the startup option block
`timescale 1ns/1ps
`include "sso_map.vh"
module sso_top_tb_top;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, run = 1'h0;
	logic capture_request = 1'h0, storage_we_in = 1'h0, we_last;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, bank_match_in = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, seed = 32'hF4F4, opt_m, rdat;
	logic [7:0] user_oe_in = 8'h0, oe_last;
	logic [1:0] clk_sel = 2'h0, rsp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, done_pin_in;
	wire configuration_clock, user_startup_clock, test_port_clock, done_pin_out, done_pin_oe;
	wire capture_strobe, global_tristate, global_write_enable, storage_we_out;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [5:0] master_clock_freq_select;
	wire [7:0] user_oe_out;
	int err_total = 0, samples_checked = 0, cyc = 0, cap_n = 0;
	sso_top u_dut (.*);
	sso_pin_model u_pins (.*);
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// ----
	// bus master
	// ----
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic pa, pw;
		pa = 1'h1;
		pw = 1'h1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (pa | pw)
		begin
			@(posedge aclk);
			pa = pa & !s_axi_awready;
			pw = pw & !s_axi_wready;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		s_axi_bready <= 1'h1;
		while (!s_axi_bvalid) @(posedge aclk);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		@(posedge aclk);
		while (!s_axi_arready) @(posedge aclk);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		@(posedge aclk);
		while (!s_axi_rvalid) @(posedge aclk);
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic poll(input int b);
		int n;
		n = 0;
		rd(`SSO_OFS_STATUS);
		while (!rdat[b] && n < 300)
		begin
			rd(`SSO_OFS_STATUS);
			n++;
		end
		chk("status bit", 1, rdat[b]);
	endtask
	task automatic seq(input logic [31:0] o, input logic [1:0] s);
		wr(`SSO_OFS_OPTIONS, o);
		clk_sel <= s;
		run <= 1'h1;
		wr(`SSO_OFS_COMMAND, 32'h1);
	endtask
	always #10 aclk = ~aclk;
	always @(posedge aclk)
	begin
		oe_last <= user_oe_in;
		we_last <= storage_we_in;
		seed <= xs(seed);
		user_oe_in <= seed[7:0];
		storage_we_in <= seed[8];
		cap_n <= cap_n + capture_strobe;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			end_sim;
		end
	end
	// ----
	// scenarios
	// ----
	initial
	begin
		logic [2:0] c, d;
		logic [1:0] s;
		int n;
		int cmds[5];
		cmds = '{4, 2, 2, 4, 2};
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(`SSO_OFS_OPTIONS);
		chk("options reset", `SSO_OPT_RESET, rdat);
		rd(4'hC);
		chk("unmapped read", `SSO_RESP_SLVERR, rsp);
		wr(4'hC, seed);
		chk("unmapped write", `SSO_RESP_SLVERR, rsp);
		repeat (3)
		begin
			opt_m = seed & `SSO_OPT_MASK;
			wr(`SSO_OFS_OPTIONS, seed);
			rd(`SSO_OFS_OPTIONS);
			chk("options", opt_m, rdat);
			chk("freq select", opt_m[22:17], master_clock_freq_select);
		end
		for (int i = 0; i < 9; i++)
		begin
			c = (i == 8) ? 3'h0 : i[2:0];
			d = (i == 8) ? 3'h7 : 3'h3;
			s = 2'(i % 3);
			seq({4'h0, i == 8, 1'h0, i[1], i[0], 7'h00, s, d, 3'h7, 3'h0, c, c}, s);
			poll(3);
			chk("phase code", 3'h4, rdat[2:0]);
			chk("tristate", c == 3'h7, global_tristate);
			chk("write enable", c != 3'h7, global_write_enable);
			chk("done enable", (i == 8) | i[0], done_pin_oe);
			if ((i == 8) | i[0])
				chk("done level", 1, done_pin_out);
			chk("user enables", (c == 3'h7) ? 8'h00 : oe_last, user_oe_out);
			chk("storage write", (c != 3'h7) & we_last, storage_we_out);
			run <= 1'h0;
		end
		bank_match_in <= 4'hB;
		seq(32'h0000342C, 2'h0);
		poll(11);
		chk("stall phase", 3'h3, rdat[2:0]);
		bank_match_in <= 4'hF;
		poll(3);
		aresetn <= 1'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(`SSO_OFS_OPTIONS);
		chk("options after reset", `SSO_OPT_RESET, rdat);
		chk("tristate after reset", 1, global_tristate);
		chk("write enable after reset", 0, global_write_enable);
		run <= 1'h0;
		wr(`SSO_OFS_OPTIONS, `SSO_OPT_RESET);
		n = cap_n;
		wr(`SSO_OFS_COMMAND, 32'h2);
		wr(`SSO_OFS_COMMAND, 32'h2);
		capture_request <= 1'h1;
		repeat (6) @(posedge aclk);
		capture_request <= 1'h0;
		repeat (6) @(posedge aclk);
		chk("free captures", n + 3, cap_n);
		wr(`SSO_OFS_OPTIONS, 32'h00803E2C);
		foreach (cmds[k]) wr(`SSO_OFS_COMMAND, cmds[k]);
		repeat (4) @(posedge aclk);
		chk("single captures", n + 5, cap_n);
		end_sim;
	end
endmodule // sso_top_tb_top
